// [tcct_consts.vh]
// constants for the thermal-compensated current telemetry block
`ifndef TCCT_CONSTS_VH
`define TCCT_CONSTS_VH

// ============================================================
// command codes on the host command port
`define TCCT_CMD_CURRENT_MONITOR_PIN_READING   8'h8c
`define TCCT_CMD_THERMAL_OFFSET 8'hd1

// ============================================================
// thermal offset setting field and reset value
`define TCCT_TOFF_LSB           0
`define TCCT_TOFF_MSB           1
`define TCCT_TOFF_RESET         8'h03
`define TCCT_TOFF_CODE_30C      2'h0
`define TCCT_TOFF_CODE_15C      2'h1
`define TCCT_TOFF_CODE_5C       2'h2
`define TCCT_TOFF_CODE_OFF      2'h3
`define TCCT_TOFF_DEG_30C       10'sd30
`define TCCT_TOFF_DEG_15C       10'sd15
`define TCCT_TOFF_DEG_5C        10'sd5

// ============================================================
// drift model: copper tempco about 0.385 %/degC, in units of 2^-16
`define TCCT_TEMPCO_Q16         18'sd252
`define TCCT_GAIN_UNITY         18'sd65536
`define TCCT_REF_TEMP_C         10'sd25

// ============================================================
// timing: clock rate and current monitor conversion period
`define TCCT_CLK_MHZ            100
`define TCCT_CURRENT_MONITOR_PIN_PERIOD_NS     108000
`define TCCT_CURRENT_MONITOR_PIN_PERIOD_CYC    ((`TCCT_CURRENT_MONITOR_PIN_PERIOD_NS * `TCCT_CLK_MHZ) / 1000)
`define TCCT_DC_DIV_CYC         64

// ============================================================
// current monitor scaling: 2.5 V code maps to 63.875 A at 0.125 A/lsb
`define TCCT_CURRENT_MONITOR_PIN_FS_LSB        10'd511
`define TCCT_CURRENT_MONITOR_PIN_CODE_SHIFT    11

`endif

// [tcct_ntc_conv.v]
// ratiometric, linearising thermistor converter
`timescale 1ns/1ps
`default_nettype none

module tcct_ntc_conv (
  // clock and reset
  input  wire              sys_clk_i,
  input  wire              nrst_i,
  // raw samples of thermistor pin and bias supply
  input  wire              smp_valid_i,
  input  wire [9:0]        ntc_code_i,
  input  wire [9:0]        vcc_code_i,
  // linear temperature, degrees c, signed
  output reg  signed [7:0] temp_o,
  output reg               temp_valid_o
);

  // ============================================================
  // breakpoints of the divider curve, ratio steps of 1/8
  function signed [7:0] tcct_bp;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    tcct_bp = 8'sd127;
        4'h1:    tcct_bp = 8'sd127;
        4'h2:    tcct_bp = 8'sd127;
        4'h3:    tcct_bp = 8'sd104;
        4'h4:    tcct_bp = 8'sd84;
        4'h5:    tcct_bp = 8'sd66;
        4'h6:    tcct_bp = 8'sd47;
        4'h7:    tcct_bp = 8'sd23;
        default: tcct_bp = -8'sd40;
      endcase
    end
  endfunction

  reg  [10:0] rem;     // running remainder
  reg  [9:0]  div;     // held divisor
  reg  [7:0]  quo;     // ratio pin/vcc in 2^-8
  reg  [3:0]  cnt;     // remaining quotient bits
  reg         busy;
  reg         done;

  wire [10:0] rem2  = {rem[9:0], 1'b0};
  wire        ge    = (rem2 >= {1'b0, div});
  wire [2:0]  seg   = quo[7:5];
  wire signed [7:0]  t_lo  = tcct_bp({1'b0, seg});
  wire signed [7:0]  t_hi  = tcct_bp({1'b0, seg} + 4'h1);
  wire signed [8:0]  t_dif = {t_hi[7], t_hi} - {t_lo[7], t_lo};
  wire signed [14:0] t_stp = t_dif * $signed({1'b0, quo[4:0]});
  wire signed [8:0]  t_int = {t_lo[7], t_lo} + t_stp[13:5];

  // ============================================================
  // restoring divide, 8 cycles, then piecewise-linear lookup
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rem          <= 11'h000;
      div          <= 10'h3ff;
      quo          <= 8'h00;
      cnt          <= 4'h0;
      busy         <= 1'b0;
      done         <= 1'b0;
      temp_o       <= 8'sd25;
      temp_valid_o <= 1'b0;
    end else begin
      done         <= 1'b0;
      temp_valid_o <= 1'b0;
      if (!busy && smp_valid_i) begin
        // ratio to the bias rail, clipped below one
        div  <= (vcc_code_i == 10'h000) ? 10'h001 : vcc_code_i;
        rem  <= (ntc_code_i >= vcc_code_i) ? {1'b0, vcc_code_i} - 11'h001
                                           : {1'b0, ntc_code_i};
        cnt  <= 4'h8;
        busy <= 1'b1;
      end else if (busy) begin
        rem  <= ge ? rem2 - {1'b0, div} : rem2;
        quo  <= {quo[6:0], ge};
        cnt  <= cnt - 4'h1;
        if (cnt == 4'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
      if (done) begin
        // nonlinear map so the code tracks temperature linearly
        temp_o       <= (t_int > 9'sd127) ? 8'sd127 : t_int[7:0];
        temp_valid_o <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// [tcct_top.v]
// thermal-compensated current sense path with telemetry registers
`timescale 1ns/1ps
`default_nettype none
`include "tcct_consts.vh"

module tcct_top #(
  parameter integer CURRENT_MONITOR_PIN_PERIOD_CYC = `TCCT_CURRENT_MONITOR_PIN_PERIOD_CYC,
  parameter integer DC_DIV_CYC      = `TCCT_DC_DIV_CYC
) (
  // clock and reset
  input  wire               sys_clk_i,
  input  wire               nrst_i,
  // host command port (serial bus command layer)
  input  wire [7:0]         cmd_code_i,
  input  wire               cmd_wr_i,
  input  wire [7:0]         cmd_wdata_i,
  input  wire               cmd_rd_i,
  output reg  [15:0]        cmd_rdata_o,
  output reg                cmd_rvalid_o,
  output reg                cmd_err_o,
  // thermistor_input and bias rail samples
  input  wire               ntc_smp_valid_i,
  input  wire [9:0]         ntc_code_i,
  input  wire [9:0]         vcc_code_i,
  // sensed inductor current, signed
  input  wire signed [15:0] isense_i,
  // current_monitor_pin voltage sample, 2048 = 2.5 V
  input  wire [11:0]        current_monitor_pin_adc_i,
  // corrected current toward monitor and overcurrent_protection
  output reg  signed [15:0] comp_current_o,
  output wire signed [15:0] ocp_current_o,
  output wire signed [7:0]  temp_o
);

  // ============================================================
  // thermal offset setting register
  reg  [7:0]  thermal_offset_setting;
  reg  [15:0] output_current_reading;

  wire [1:0] toff_code = thermal_offset_setting[`TCCT_TOFF_MSB:`TCCT_TOFF_LSB];

  // host writes land whenever they arrive, no busy window
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      thermal_offset_setting <= `TCCT_TOFF_RESET;
    end else if (cmd_wr_i && cmd_code_i == `TCCT_CMD_THERMAL_OFFSET) begin
      thermal_offset_setting <= cmd_wdata_i;
    end
  end

  // ============================================================
  // read side: one cycle latency, unknown codes flag an error
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cmd_rdata_o  <= 16'h0000;
      cmd_rvalid_o <= 1'b0;
      cmd_err_o    <= 1'b0;
    end else begin
      cmd_rvalid_o <= cmd_rd_i;
      cmd_err_o    <= 1'b0;
      if (cmd_rd_i) begin
        case (cmd_code_i)
          `TCCT_CMD_CURRENT_MONITOR_PIN_READING: begin
            cmd_rdata_o <= output_current_reading;
          end
          `TCCT_CMD_THERMAL_OFFSET: begin
            cmd_rdata_o <= {8'h00, thermal_offset_setting};
          end
          default: begin
            cmd_rdata_o <= 16'h0000;
            cmd_err_o   <= 1'b1;
          end
        endcase
      end else if (cmd_wr_i && cmd_code_i != `TCCT_CMD_THERMAL_OFFSET) begin
        // writes to read-only or unknown codes are dropped
        cmd_err_o <= 1'b1;
      end
    end
  end

  // ============================================================
  // thermistor conversion
  tcct_ntc_conv u_ntc (
    .sys_clk_i    (sys_clk_i),
    .nrst_i       (nrst_i),
    .smp_valid_i  (ntc_smp_valid_i),
    .ntc_code_i   (ntc_code_i),
    .vcc_code_i   (vcc_code_i),
    .temp_o       (temp_o),
    .temp_valid_o ()
  );

  // ============================================================
  // split sense current into dc (slow average) and ac residue
  reg  signed [15:0] dc_avg;        // dc component estimate
  reg  [15:0]        dc_div_cnt;    // divider for averaging rate
  wire               dc_tick = (dc_div_cnt == 16'h0000);
  wire signed [16:0] dc_err  = {isense_i[15], isense_i} - {dc_avg[15], dc_avg};
  wire signed [16:0] dc_step = dc_err >>> 4;
  wire signed [16:0] ac_part = dc_err;

  // slow first-order average; ac rides through untouched
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      dc_avg     <= 16'sh0000;
      dc_div_cnt <= 16'h0000;
    end else begin
      dc_div_cnt <= dc_tick ? DC_DIV_CYC[15:0] - 16'h0001 : dc_div_cnt - 16'h0001;
      if (dc_tick) begin
        dc_avg <= dc_avg + dc_step[15:0];
      end
    end
  end

  // ============================================================
  // gain from offset-corrected temperature
  reg  signed [9:0] toff_deg;  // decoded offset in degrees

  // offset decode
  always @* begin
    case (toff_code)
      `TCCT_TOFF_CODE_30C: toff_deg = `TCCT_TOFF_DEG_30C;
      `TCCT_TOFF_CODE_15C: toff_deg = `TCCT_TOFF_DEG_15C;
      `TCCT_TOFF_CODE_5C:  toff_deg = `TCCT_TOFF_DEG_5C;
      default:             toff_deg = 10'sd0;
    endcase
  end

  // sense element sits hotter than the thermistor by the offset
  wire signed [9:0]  dtemp   = {{2{temp_o[7]}}, temp_o} + toff_deg - `TCCT_REF_TEMP_C;
  wire signed [27:0] gadj    = `TCCT_TEMPCO_Q16 * dtemp;
  wire signed [17:0] gain    = `TCCT_GAIN_UNITY - gadj[17:0];
  wire signed [33:0] dc_prod = dc_avg * gain;
  // linear first-order inverse of copper drift; fine over board range
  wire signed [17:0] dc_corr = dc_prod[33:16];
  wire signed [18:0] sum_c   = {dc_corr[17], dc_corr} + {{2{ac_part[16]}}, ac_part};

  // saturate to 16 bits so a hot reading never wraps negative
  function signed [15:0] tcct_sat;
    input signed [18:0] v;
    begin
      if (v > 19'sd32767) begin
        tcct_sat = 16'sh7fff;
      end else if (v < -19'sd32768) begin
        tcct_sat = 16'sh8000;
      end else begin
        tcct_sat = v[15:0];
      end
    end
  endfunction

  // ============================================================
  // corrected current register
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      comp_current_o <= 16'sh0000;
    end else if (toff_code == `TCCT_TOFF_CODE_OFF) begin
      comp_current_o <= isense_i;         // bypass
    end else begin
      comp_current_o <= tcct_sat(sum_c);  // dc corrected, ac raw
    end
  end

  // one corrected signal feeds both consumers
  assign ocp_current_o = comp_current_o;

  // ============================================================
  // current monitor telemetry
  reg  [31:0] current_monitor_pin_cnt;   // conversion period counter
  wire        current_monitor_pin_tick = (current_monitor_pin_cnt == 32'h0000_0000);
  wire [21:0] current_monitor_pin_prod = current_monitor_pin_adc_i * `TCCT_CURRENT_MONITOR_PIN_FS_LSB;
  wire [21:0] current_monitor_pin_scl  = current_monitor_pin_prod >> `TCCT_CURRENT_MONITOR_PIN_CODE_SHIFT;

  // register changes only on a tick, whole word at once
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      current_monitor_pin_cnt               <= 32'h0000_0000;
      output_current_reading <= 16'h0000;
    end else begin
      if (current_monitor_pin_tick) begin
        current_monitor_pin_cnt <= CURRENT_MONITOR_PIN_PERIOD_CYC[31:0] - 32'h0000_0001;
        // linear scale, 2048 code reads 511 lsb of 0.125 a
        output_current_reading <= current_monitor_pin_scl[15:0];
      end else begin
        current_monitor_pin_cnt <= current_monitor_pin_cnt - 32'h0000_0001;
      end
    end
  end

endmodule
`default_nettype wire

// [tcct_chk_assertions.sv]
// checker for the telemetry block ports
`timescale 1ns/1ps
`default_nettype none
module tcct_chk (
  input wire logic               sys_clk_i, nrst_i, cmd_wr_i, cmd_rd_i,
  input wire logic [7:0]         cmd_code_i, cmd_wdata_i,
  input wire logic [15:0]        cmd_rdata_o,
  input wire logic               cmd_rvalid_o, cmd_err_o, ntc_smp_valid_i,
  input wire logic [9:0]         ntc_code_i, vcc_code_i,
  input wire logic signed [15:0] isense_i, comp_current_o, ocp_current_o,
  input wire logic [11:0]        current_monitor_pin_adc_i,
  input wire logic signed [7:0]  temp_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] off_q; // host view of the offset byte
  always_ff @(posedge sys_clk_i)
    if (!nrst_i) off_q <= 8'h03;
    else if (cmd_wr_i && cmd_code_i == 8'hd1) off_q <= cmd_wdata_i;
  // ==========
  // command port
  AST_RD_ANS: assert property (cmd_rd_i |=> cmd_rvalid_o) else $error("read unanswered");
  AST_RV_CAUSE: assert property (cmd_rvalid_o |-> $past(cmd_rd_i))
    else $error("stray read valid");
  AST_RD_BAD: assert property (cmd_rd_i && cmd_code_i != 8'h8c && cmd_code_i != 8'hd1
    |=> cmd_err_o && cmd_rdata_o == 16'h0000) else $error("bad read not refused");
  AST_WR_RO: assert property (cmd_wr_i && cmd_code_i == 8'h8c |=> cmd_err_o)
    else $error("reading register took a write");
  AST_RD_OFF: assert property (cmd_rd_i && cmd_code_i == 8'hd1
    |=> cmd_rdata_o == {8'h00, $past(off_q)}) else $error("offset readback");
  AST_RD_CURRENT_MONITOR_PIN: assert property (cmd_rd_i && cmd_code_i == 8'h8c
    |=> !cmd_err_o && cmd_rdata_o <= 16'd1021) else $error("reading range");
  // ==========
  // current path and temperature
  AST_OCP: assert property (ocp_current_o == comp_current_o) else $error("ocp differs");
  AST_BYPASS: assert property ($past(nrst_i) && $past(off_q[1:0]) == 2'h3
    |-> comp_current_o == $past(isense_i)) else $error("off code not bypassed");
  AST_OCP_BYP: assert property ($past(nrst_i) && $past(off_q[1:0]) == 2'h3
    |-> ocp_current_o == $past(isense_i)) else $error("ocp not fed from bypass");
  AST_TEMP: assert property ($past(nrst_i) && $changed(temp_o)
    |-> $past(ntc_smp_valid_i, 10)) else $error("temp moved without sample");
  cover property (cmd_rd_i && cmd_code_i == 8'h55);
  cover property ($changed(temp_o));
  cover property (cmd_wr_i && cmd_code_i == 8'hd1 && cmd_wdata_i == 8'h00);
endmodule
bind tcct_top tcct_chk tcct_chk_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_code_i(cmd_code_i),
  .cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o),
  .cmd_err_o(cmd_err_o), .ntc_smp_valid_i(ntc_smp_valid_i), .ntc_code_i(ntc_code_i),
  .vcc_code_i(vcc_code_i), .isense_i(isense_i), .comp_current_o(comp_current_o),
  .ocp_current_o(ocp_current_o), .current_monitor_pin_adc_i(current_monitor_pin_adc_i), .temp_o(temp_o));
`default_nettype wire

// [tcct_front_model.sv]
// front end model: thermistor and bias rail sample source
`timescale 1ns/1ps
`default_nettype none
module tcct_front_model #(
  parameter int GAP = 16 // strobe spacing, raise for a slow source
) (
  input  wire logic       clk_i,
  input  wire logic [9:0] ntc_set_i,
  input  wire logic [9:0] vcc_set_i,
  output var logic        strobe_o,
  output var logic [9:0]  ntc_o,
  output var logic [9:0]  vcc_o
);
  int cnt = 0; // strobe spacing counter
  initial {strobe_o, ntc_o, vcc_o} = '0;
  // codes only valid with strobe; inverted between so stale data never looks good
  always @(negedge clk_i) begin
    cnt = (cnt + 1) % GAP;
    strobe_o <= (cnt == 0);
    ntc_o    <= (cnt == 0) ? ntc_set_i : ~ntc_set_i;
    vcc_o    <= (cnt == 0) ? vcc_set_i : ~vcc_set_i;
  end
endmodule
`default_nettype wire

// [tcct_tb.sv]
// self-checking bench for the telemetry block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic               sys_clk_i = '0, nrst_i = '0, cmd_wr_i = '0, cmd_rd_i = '0, smp;
  logic [7:0]         cmd_code_i = '0, cmd_wdata_i = '0;
  logic [9:0]         ntc_set = 10'h100, vcc_set = 10'h200, ntc_code, vcc_code;
  logic signed [15:0] isense = '0, comp, overcurrent_protection, last, tune[3];
  logic [11:0]        current_monitor_pin_adc = '0;
  wire  [15:0]        rdata;
  wire                rvalid, err;
  wire signed [7:0]   temp;
  int                 n_errors = 0, n_compared = 0, deg[3] = '{30, 15, 5};
  tcct_front_model tcct_front_model_i (.clk_i(sys_clk_i), .ntc_set_i(ntc_set),
    .vcc_set_i(vcc_set), .strobe_o(smp), .ntc_o(ntc_code), .vcc_o(vcc_code));
  // short periods keep the run brief
  tcct_top #(.CURRENT_MONITOR_PIN_PERIOD_CYC(20), .DC_DIV_CYC(2)) tcct_top_i (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .cmd_code_i(cmd_code_i), .cmd_wr_i(cmd_wr_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_rd_i(cmd_rd_i), .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid), .cmd_err_o(err),
    .ntc_smp_valid_i(smp), .ntc_code_i(ntc_code), .vcc_code_i(vcc_code), .isense_i(isense),
    .current_monitor_pin_adc_i(current_monitor_pin_adc), .comp_current_o(comp), .ocp_current_o(overcurrent_protection), .temp_o(temp));
  task automatic cmp(input string s, input logic [15:0] x, g);
    n_compared++;
    if (g !== x) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic near(input string s, input logic signed [15:0] x, g, input int t);
    n_compared++;
    if (((g - x) <= t && (x - g) <= t) !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", s, x, g);
    end
  endtask
  // one strobe cycle; answer is registered at the taking edge
  task automatic xfer(input logic w, input logic [7:0] c, d, input logic [15:0] x,
                      input logic xe);
    int k;
    @(negedge sys_clk_i);
    {cmd_wr_i, cmd_rd_i, cmd_code_i, cmd_wdata_i} = {w, !w, c, d};
    @(negedge sys_clk_i);
    {cmd_wr_i, cmd_rd_i} = 2'b00;
    for (k = 0; k < 4 && !w && rvalid !== 1'b1 && err !== 1'b1; k++) @(negedge sys_clk_i);
    if (k == 4) begin
      n_errors++;
      summarize();
    end else begin
      cmp("err", {15'h0, xe}, {15'h0, err});
      cmp("rvalid", {15'h0, !w}, {15'h0, rvalid});
      if (!w) cmp("rdata", x, rdata);
    end
  endtask
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial forever #5 sys_clk_i = ~sys_clk_i;
  initial begin
    #300us;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (10) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    xfer(1'b0, 8'hd1, 8'h00, 16'h0003, 1'b0);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 8'hd1, i[7:0], 16'h0000, 1'b0);
      xfer(1'b0, 8'hd1, 8'h00, i[15:0], 1'b0);
    end
    xfer(1'b1, 8'h8c, 8'h07, 16'h0000, 1'b1);
    xfer(1'b0, 8'h55, 8'h00, 16'h0000, 1'b1);
    $display("test registers done");
    isense = -16'sd1234;
    repeat (3) @(negedge sys_clk_i);
    cmp("bypass", isense, comp);
    cmp("ocp", isense, overcurrent_protection);
    repeat (40) @(negedge sys_clk_i);
    cmp("temp", 16'd84, {{8{temp[7]}}, temp});
    ntc_set = 10'h180;
    repeat (40) @(negedge sys_clk_i);
    cmp("temp", 16'd47, {{8{temp[7]}}, temp});
    ntc_set = 10'h100;
    isense = 16'sd16000;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 8'hd1, i[7:0], 16'h0000, 1'b0);
      repeat (400) @(negedge sys_clk_i);
      near("gain", 16000 * (65536 - 252 * (59 + deg[i])) / 65536, comp, 8);
      tune[i] = comp;
    end
    // a larger offset must pull the monitor down, the lever host tuning relies on
    cmp("tune dir", 16'h0001, {15'h0, tune[0] < tune[1] && tune[1] < tune[2]});
    last = comp;
    isense = 16'sd20000;
    @(negedge sys_clk_i);
    near("ac step", last + 16'sd4000, comp, 100);
    $display("test current path done");
    current_monitor_pin_adc = 12'h800;
    repeat (50) @(negedge sys_clk_i);
    xfer(1'b0, 8'h8c, 8'h00, 16'd511, 1'b0);
    current_monitor_pin_adc = 12'h400;
    repeat (50) @(negedge sys_clk_i);
    xfer(1'b0, 8'h8c, 8'h00, 16'd255, 1'b0);
    $display("test telemetry done");
    summarize();
  end
endmodule
`default_nettype wire
